// ### common/preset_seq_pkg.sv
/*
 Package for the preset and sequence command unit: command codes,
 sequencer states, value limits and the structs that carry commands,
 answers and output settings. Assumes a single clock domain.
*/
package preset_seq_pkg;

	localparam int VAL_W = 10;
	localparam int STEP_W = 7;
	localparam int SET_W = 16;
	localparam int PRESET_W = 2;
	localparam int NUM_PRESETS = 3;

	localparam logic [VAL_W-1:0] PRESET_MAX = 10'h003;
	localparam logic [VAL_W-1:0] STEP_MAX = 10'h063;
	localparam logic [VAL_W-1:0] LOOP_MAX = 10'h3e7;
	localparam logic [VAL_W-1:0] STATE_MAX = 10'h002;
	localparam logic [STEP_W-1:0] STEP_LAST = 7'h63;
	localparam logic [STEP_W-1:0] STEP_ONE = 7'h01;
	localparam logic [STEP_W-1:0] STEP_RST = 7'h00;
	localparam logic [VAL_W-1:0] LOOP_ONE = 10'h001;
	localparam logic [VAL_W-1:0] VAL_ZERO = 10'h000;
	localparam logic [PRESET_W-1:0] PRESET_NONE = 2'h0;

	typedef enum logic [2:0] {
		OP_RECALL = 3'b000,
		OP_STORE = 3'b001,
		OP_STATE = 3'b010,
		OP_JUMP = 3'b011,
		OP_FIRST = 3'b100,
		OP_LAST = 3'b101,
		OP_LOOPS = 3'b110,
		OP_UNUSED = 3'b111
	} op_t;

	typedef enum logic [1:0] {
		SEQ_STOP = 2'b00,
		SEQ_PAUSE = 2'b01,
		SEQ_RUN = 2'b10,
		SEQ_BAD = 2'b11
	} seq_state_t;

	typedef struct packed {
		logic valid;
		op_t op;
		logic query;
		logic [VAL_W-1:0] value;
	} cmd_t;

	typedef struct packed {
		logic valid;
		logic error;
		logic [VAL_W-1:0] data0;
		logic [VAL_W-1:0] data1;
	} rsp_t;

	typedef struct packed {
		logic [SET_W-1:0] volt;
		logic [SET_W-1:0] curr;
		logic [SET_W-1:0] power;
	} setting_t;

endpackage

// ### hw/preset_and_sequence_command_unit.sv
/*
 Preset and sequence command unit: executes decoded remote commands for
 the preset memory and the step sequencer, and answers queries.
 Every command gets one answer a cycle later; a refused command stores
 nothing and answers with the error bit and zero data.
 Assumes commands, present settings and step completion come from logic
 on the same clock, one command per valid cycle. A finished step is only
 counted while the sequence runs; preset storage clears on reset.
*/
`timescale 1ns/1ps
module preset_and_sequence_command_unit (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire preset_seq_pkg::cmd_t cmd_i,
	input wire preset_seq_pkg::setting_t present_i,
	input wire logic step_done_i,
	output preset_seq_pkg::rsp_t rsp_o,
	output preset_seq_pkg::setting_t recall_o,
	output logic recall_load_o,
	output logic [preset_seq_pkg::PRESET_W-1:0] preset_sel_o,
	output preset_seq_pkg::seq_state_t seq_state_o,
	output logic [preset_seq_pkg::STEP_W-1:0] step_o,
	output logic [preset_seq_pkg::VAL_W-1:0] loops_done_o
);

	preset_seq_pkg::setting_t preset_mem [preset_seq_pkg::NUM_PRESETS];
	logic [preset_seq_pkg::STEP_W-1:0] first_reg;
	logic [preset_seq_pkg::STEP_W-1:0] last_reg;
	logic [preset_seq_pkg::VAL_W-1:0] loop_limit_reg;

	wire running = (seq_state_o == preset_seq_pkg::SEQ_RUN);
	wire paused = (seq_state_o == preset_seq_pkg::SEQ_PAUSE);
	wire is_set = cmd_i.valid && !cmd_i.query;
	wire [preset_seq_pkg::VAL_W-1:0] val = cmd_i.value;
	wire [preset_seq_pkg::STEP_W-1:0] val_step = val[preset_seq_pkg::STEP_W-1:0];
	wire [preset_seq_pkg::PRESET_W-1:0] val_preset = val[preset_seq_pkg::PRESET_W-1:0];
	wire step_ok = (val <= preset_seq_pkg::STEP_MAX);

	// Refusal per command kind
	wire err_recall = running || (val > preset_seq_pkg::PRESET_MAX);
	wire err_store = running || cmd_i.query || (val == preset_seq_pkg::VAL_ZERO)
		|| (val > preset_seq_pkg::PRESET_MAX);
	wire err_state = val > preset_seq_pkg::STATE_MAX;
	wire err_jump = running || !paused || !step_ok;
	wire err_loops = val > preset_seq_pkg::LOOP_MAX;

	// Queries are refused only for store and the unused code
	logic cmd_err;
	always_comb begin
		unique case (cmd_i.op)
			preset_seq_pkg::OP_RECALL: cmd_err = err_recall && !cmd_i.query;
			preset_seq_pkg::OP_STORE: cmd_err = err_store;
			preset_seq_pkg::OP_STATE: cmd_err = err_state && !cmd_i.query;
			preset_seq_pkg::OP_JUMP: cmd_err = err_jump && !cmd_i.query;
			preset_seq_pkg::OP_FIRST: cmd_err = !step_ok && !cmd_i.query;
			preset_seq_pkg::OP_LAST: cmd_err = !step_ok && !cmd_i.query;
			preset_seq_pkg::OP_LOOPS: cmd_err = err_loops && !cmd_i.query;
			default: cmd_err = 1'b1;
		endcase
	end

	wire cmd_ok = is_set && !cmd_err;
	wire do_recall = cmd_ok && (cmd_i.op == preset_seq_pkg::OP_RECALL);
	wire do_store = cmd_ok && (cmd_i.op == preset_seq_pkg::OP_STORE);
	wire do_state = cmd_ok && (cmd_i.op == preset_seq_pkg::OP_STATE);
	wire do_jump = cmd_ok && (cmd_i.op == preset_seq_pkg::OP_JUMP);
	wire do_first = cmd_ok && (cmd_i.op == preset_seq_pkg::OP_FIRST);
	wire do_last = cmd_ok && (cmd_i.op == preset_seq_pkg::OP_LAST);
	wire do_loops = cmd_ok && (cmd_i.op == preset_seq_pkg::OP_LOOPS);

	// Query answers, upper bits zero
	logic [preset_seq_pkg::VAL_W-1:0] q0;
	logic [preset_seq_pkg::VAL_W-1:0] q1;
	always_comb begin
		q0 = preset_seq_pkg::VAL_ZERO;
		q1 = preset_seq_pkg::VAL_ZERO;
		unique case (cmd_i.op)
			preset_seq_pkg::OP_RECALL: q0 = {8'h00, preset_sel_o};
			preset_seq_pkg::OP_STATE: q0 = {8'h00, seq_state_o};
			preset_seq_pkg::OP_JUMP: begin
				q0 = {3'h0, step_o};
				q1 = loops_done_o;
			end
			preset_seq_pkg::OP_FIRST: q0 = {3'h0, first_reg};
			preset_seq_pkg::OP_LAST: q0 = {3'h0, last_reg};
			preset_seq_pkg::OP_LOOPS: q0 = loop_limit_reg;
			default: q0 = preset_seq_pkg::VAL_ZERO;
		endcase
	end

	// Sequencer progress on a completed step
	wire at_last = (step_o == last_reg);
	wire [preset_seq_pkg::VAL_W-1:0] loops_inc = loops_done_o + preset_seq_pkg::LOOP_ONE;
	// A limit of zero lets the sequence loop forever
	wire limit_hit = (loop_limit_reg != preset_seq_pkg::VAL_ZERO)
		&& (loops_inc >= loop_limit_reg);
	// Past the highest step the index wraps to zero
	wire [preset_seq_pkg::STEP_W-1:0] step_inc = (step_o == preset_seq_pkg::STEP_LAST)
		? preset_seq_pkg::STEP_RST : step_o + preset_seq_pkg::STEP_ONE;
	wire advance = running && step_done_i && !do_state;
	wire new_state_run = (val[1:0] == preset_seq_pkg::SEQ_RUN);
	wire start_fresh = do_state && new_state_run
		&& (seq_state_o == preset_seq_pkg::SEQ_STOP);

	// A state command wins over a finished step in the same cycle
	preset_seq_pkg::seq_state_t state_next;
	logic [preset_seq_pkg::STEP_W-1:0] step_next;
	logic [preset_seq_pkg::VAL_W-1:0] loops_next;
	always_comb begin
		state_next = seq_state_o;
		step_next = step_o;
		loops_next = loops_done_o;
		if (do_state) begin
			state_next = preset_seq_pkg::seq_state_t'(val[1:0]);
			// Only stop to run reloads the first step; pause to run resumes
			if (start_fresh) begin
				step_next = first_reg;
				loops_next = preset_seq_pkg::VAL_ZERO;
			end
		end else if (do_jump) begin
			step_next = val_step;
		end else if (advance) begin
			if (at_last) begin
				step_next = first_reg;
				loops_next = loops_inc;
				if (limit_hit)
					state_next = preset_seq_pkg::SEQ_STOP;
			end else begin
				step_next = step_inc;
			end
		end
	end

	// Sequencer state, step and completed passes
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			seq_state_o <= preset_seq_pkg::SEQ_STOP;
			step_o <= preset_seq_pkg::STEP_RST;
			loops_done_o <= preset_seq_pkg::VAL_ZERO;
		end else begin
			seq_state_o <= state_next;
			step_o <= step_next;
			loops_done_o <= loops_next;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			first_reg <= preset_seq_pkg::STEP_RST;
			last_reg <= preset_seq_pkg::STEP_RST;
			loop_limit_reg <= preset_seq_pkg::VAL_ZERO;
		end else begin
			if (do_first)
				first_reg <= val_step;
			if (do_last)
				last_reg <= val_step;
			if (do_loops)
				loop_limit_reg <= val;
		end
	end

	// Preset slots 1..3 live at indices 0..2
	genvar g;
	generate
		for (g = 0; g < preset_seq_pkg::NUM_PRESETS; g++) begin : slot
			localparam logic [preset_seq_pkg::PRESET_W-1:0] SEL = preset_seq_pkg::PRESET_W'(g + 1);
			always_ff @(posedge clk_i or posedge sys_rst_i) begin
				if (sys_rst_i)
					preset_mem[g] <= '0;
				else if (do_store && val_preset == SEL)
					preset_mem[g] <= present_i;
			end
		end
	endgenerate

	// Recall 0 clears the selection and keeps the last loaded settings
	wire recall_load = do_recall && (val_preset != preset_seq_pkg::PRESET_NONE);
	wire [preset_seq_pkg::PRESET_W-1:0] recall_idx = val_preset - 2'h1;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			preset_sel_o <= preset_seq_pkg::PRESET_NONE;
			recall_o <= '0;
			recall_load_o <= 1'b0;
		end else begin
			recall_load_o <= recall_load;
			if (do_recall)
				preset_sel_o <= val_preset;
			if (recall_load)
				recall_o <= preset_mem[recall_idx];
		end
	end

	// Answer data is zero for settings and refused commands
	wire answer_ok = cmd_i.valid && cmd_i.query && !cmd_err;
	wire rsp_err = cmd_i.valid && cmd_err;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rsp_o <= '0;
		end else begin
			rsp_o.valid <= cmd_i.valid;
			rsp_o.error <= rsp_err;
			rsp_o.data0 <= answer_ok ? q0 : preset_seq_pkg::VAL_ZERO;
			rsp_o.data1 <= answer_ok ? q1 : preset_seq_pkg::VAL_ZERO;
		end
	end

endmodule

// ### testbench/preset_seq_asserts.sv
/*
 Checker on the command unit ports.
 Assumes it is bound to the unit from the testbench top.
*/
`timescale 1ns/1ps
module preset_seq_asserts (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire preset_seq_pkg::cmd_t cmd_i,
	input wire preset_seq_pkg::rsp_t rsp_o,
	input wire logic recall_load_o,
	input wire logic [1:0] preset_sel_o,
	input wire preset_seq_pkg::seq_state_t seq_state_o,
	input wire logic [6:0] step_o,
	input wire logic [9:0] loops_done_o
);
	wire set = cmd_i.valid && !cmd_i.query;
	wire qry = cmd_i.valid && cmd_i.query;
	wire run = seq_state_o == preset_seq_pkg::SEQ_RUN;
	wire rc = cmd_i.op == preset_seq_pkg::OP_RECALL;
	wire sv = cmd_i.op == preset_seq_pkg::OP_STORE;
	wire sm = cmd_i.op == preset_seq_pkg::OP_STATE;
	wire jp = cmd_i.op == preset_seq_pkg::OP_JUMP;
	wire lp = cmd_i.op == preset_seq_pkg::OP_LOOPS;
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence run_go;
		set && sm && cmd_i.value == 10'h002 && seq_state_o == preset_seq_pkg::SEQ_STOP;
	endsequence
	answer_next_a: assert property (cmd_i.valid |=> rsp_o.valid)
		else $error("no answer");
	busy_refuse_a: assert property (set && run && (rc || sv || jp) |=> rsp_o.error)
		else $error("busy command taken");
	store_query_a: assert property (qry && sv |=> rsp_o.error)
		else $error("store query taken");
	run_start_a: assert property (run_go |=> run && loops_done_o == 10'h000)
		else $error("run start wrong");
	state_query_a: assert property (qry && sm |=> rsp_o.data0 == {8'h00, $past(seq_state_o)})
		else $error("state answer wrong");
	jump_gate_a: assert property (set && jp && seq_state_o != preset_seq_pkg::SEQ_PAUSE
		|=> rsp_o.error)
		else $error("jump not refused");
	jump_pair_a: assert property (qry && jp |=> rsp_o.data0 == {3'h0, $past(step_o)}
		&& rsp_o.data1 == $past(loops_done_o))
		else $error("jump answer wrong");
	recall_load_a: assert property (set && rc && !run && cmd_i.value inside {[1:3]}
		|=> recall_load_o && preset_sel_o == $past(cmd_i.value[1:0]))
		else $error("recall not loaded");
	preset_query_a: assert property (qry && rc |=> rsp_o.data0 == {8'h00, $past(preset_sel_o)})
		else $error("preset answer wrong");
	loop_range_a: assert property (set && lp && cmd_i.value > 10'h3e7 |=> rsp_o.error)
		else $error("loop count not refused");
endmodule

// ### testbench/cmd_host.sv
/*
 Remote host model: issues one command at a time and keeps the answer.
 Assumes the unit answers one cycle after each command.
*/
`timescale 1ns/1ps
module cmd_host (
	input wire logic clk_i,
	input wire preset_seq_pkg::rsp_t rsp_i,
	output preset_seq_pkg::cmd_t cmd_o
);
	preset_seq_pkg::rsp_t last;
	initial cmd_o = '0;
	task automatic issue(input preset_seq_pkg::op_t op, input logic q, input logic [9:0] v);
		@(posedge clk_i) cmd_o <= '{1'b1, op, q, v};
		// Idle bus shows the inverted value, never the stale one
		@(posedge clk_i) cmd_o <= '{1'b0, op, q, ~v};
		#1 last = rsp_i;
	endtask
endmodule

// ### testbench/preset_and_sequence_command_unit_test.sv
/*
 Self-checking bench for the preset and sequence command unit.
 Assumes the host model and the checker file are compiled with it.
*/
`timescale 1ns/1ps
module preset_and_sequence_command_unit_test;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic step_done_i = 1'b0;
	preset_seq_pkg::setting_t present_i = '0;
	preset_seq_pkg::cmd_t cmd_i;
	preset_seq_pkg::rsp_t rsp_o;
	preset_seq_pkg::setting_t recall_o;
	logic recall_load_o;
	logic [1:0] preset_sel_o;
	preset_seq_pkg::seq_state_t seq_state_o;
	logic [6:0] step_o;
	logic [9:0] loops_done_o;
	int fail_count = 0;
	int samples_checked = 0;
	always #25 clk_i = ~clk_i;
	cmd_host host (.clk_i, .rsp_i(rsp_o), .cmd_o(cmd_i));
	preset_and_sequence_command_unit dut (.clk_i, .sys_rst_i, .cmd_i, .present_i, .step_done_i,
		.rsp_o, .recall_o, .recall_load_o, .preset_sel_o, .seq_state_o, .step_o, .loops_done_o);
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [2:0] op, input logic q, input logic [9:0] v, input logic e);
		host.issue(preset_seq_pkg::op_t'(op), q, v);
		chk({47'h0, host.last.error}, {47'h0, e});
	endtask
	task automatic step();
		@(posedge clk_i) step_done_i <= 1'b1;
		@(posedge clk_i) step_done_i <= 1'b0;
		#1;
	endtask
	task automatic t_preset();
		@(posedge clk_i) present_i <= 48'h1111_2222_3333;
		cmd(3'h1, 1'b0, 10'h002, 1'b0);
		@(posedge clk_i) present_i <= 48'h4444_5555_6666;
		cmd(3'h1, 1'b1, 10'h001, 1'b1);
		cmd(3'h1, 1'b0, 10'h000, 1'b1);
		cmd(3'h0, 1'b0, 10'h002, 1'b0);
		chk(recall_o, 48'h1111_2222_3333);
		chk({47'h0, recall_load_o}, 48'h1);
		cmd(3'h0, 1'b1, 10'h000, 1'b0);
		chk({38'h0, host.last.data0}, 48'h2);
		cmd(3'h0, 1'b0, 10'h004, 1'b1);
		cmd(3'h0, 1'b0, 10'h000, 1'b0);
		chk({46'h0, preset_sel_o}, 48'h0);
		chk({47'h0, recall_load_o}, 48'h0);
		chk(recall_o, 48'h1111_2222_3333);
		$display("preset test done");
	endtask
	task automatic t_seq();
		cmd(3'h4, 1'b0, 10'h002, 1'b0);
		cmd(3'h5, 1'b0, 10'h003, 1'b0);
		cmd(3'h6, 1'b0, 10'h002, 1'b0);
		cmd(3'h6, 1'b0, 10'h3e8, 1'b1);
		cmd(3'h7, 1'b1, 10'h000, 1'b1);
		cmd(3'h4, 1'b1, 10'h000, 1'b0);
		chk({38'h0, host.last.data0}, 48'h2);
		cmd(3'h3, 1'b0, 10'h005, 1'b1);
		cmd(3'h2, 1'b0, 10'h002, 1'b0);
		chk({41'h0, step_o}, 48'h2);
		cmd(3'h0, 1'b0, 10'h001, 1'b1);
		cmd(3'h2, 1'b1, 10'h000, 1'b0);
		chk({38'h0, host.last.data0}, 48'h2);
		step();
		chk({41'h0, step_o}, 48'h3);
		step();
		chk({31'h0, step_o, loops_done_o}, {31'h0, 7'h02, 10'h001});
		step();
		step();
		chk({46'h0, seq_state_o}, 48'h0);
		cmd(3'h2, 1'b0, 10'h003, 1'b1);
		cmd(3'h2, 1'b0, 10'h001, 1'b0);
		cmd(3'h3, 1'b0, 10'h063, 1'b0);
		cmd(3'h3, 1'b0, 10'h064, 1'b1);
		step();
		cmd(3'h3, 1'b1, 10'h000, 1'b0);
		chk({28'h0, host.last.data0, host.last.data1}, {28'h0, 10'h063, 10'h002});
		cmd(3'h6, 1'b0, 10'h000, 1'b0);
		cmd(3'h5, 1'b0, 10'h063, 1'b0);
		cmd(3'h2, 1'b0, 10'h002, 1'b0);
		step();
		chk({46'h0, seq_state_o}, 48'h2);
		$display("sequence test done");
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		t_preset();
		t_seq();
		print_verdict();
	end
endmodule
bind preset_and_sequence_command_unit preset_seq_asserts chk_u (.clk_i, .sys_rst_i, .cmd_i,
	.rsp_o, .recall_load_o, .preset_sel_o, .seq_state_o, .step_o, .loops_done_o);
